// [wdt_pkg.sv]
// Shared constants for the I/O-read watchdog and its host-side controller.
// Assumes one 50 MHz system clock shared by both ends.
package wdt_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned TICK_TIME_MS    = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / MS_PER_S * TICK_TIME_MS;
  localparam int unsigned OUT_HOLD_CYCLES = 16;
  localparam int unsigned SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // I/O port map
  // ----------------------------------------------------------------
  localparam int unsigned IO_ADDR_W        = 16;
  localparam int unsigned IO_DATA_W        = 8;
  localparam logic [15:0] ENABLE_PORT_ADDR = 16'h0443;
  localparam logic [15:0] DISABLE_PORT_ADDR = 16'h0043;
  localparam logic [7:0]  IO_READ_VALUE    = 8'h00;

  // ----------------------------------------------------------------
  // Timeout period jumper: bit3 pins 1-2 ... bit0 pins 7-8, 1 = closed
  // ----------------------------------------------------------------
  localparam int unsigned PER_JMP_W = 4;
  localparam logic [3:0]  PER_SEL_1S   = 4'h2;
  localparam logic [3:0]  PER_SEL_2S   = 4'h3;
  localparam logic [3:0]  PER_SEL_10S  = 4'h4;
  localparam logic [3:0]  PER_SEL_20S  = 4'h5;
  localparam logic [3:0]  PER_SEL_110S = 4'h8;
  localparam logic [3:0]  PER_SEL_220S = 4'h9;

  // Periods in seconds
  localparam int unsigned PERIOD_W    = 8;
  localparam logic [7:0]  PERIOD_1S   = 8'h01;
  localparam logic [7:0]  PERIOD_2S   = 8'h02;
  localparam logic [7:0]  PERIOD_10S  = 8'h0A;
  localparam logic [7:0]  PERIOD_20S  = 8'h14;
  localparam logic [7:0]  PERIOD_110S = 8'h6E;
  localparam logic [7:0]  PERIOD_220S = 8'hDC;
  localparam logic [7:0]  SEC_LAST    = 8'h01;

  // ----------------------------------------------------------------
  // Expiry action jumper: bit1 pins 1-2, bit0 pins 2-3, 1 = closed
  // ----------------------------------------------------------------
  localparam int unsigned ACT_JMP_W = 2;
  localparam logic [1:0]  ACT_RESET = 2'h1;
  localparam logic [1:0]  ACT_NMI   = 2'h2;

  // ----------------------------------------------------------------
  // Host controller registers
  // ----------------------------------------------------------------
  localparam int unsigned REG_DEC_W      = 8;
  localparam logic [7:0]  REG_CMD        = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h0C;
  localparam logic [7:0]  REG_READ_DATA  = 8'h10;
  localparam int unsigned CMD_ENABLE_BIT  = 0;
  localparam int unsigned CMD_DISABLE_BIT = 1;
  localparam int unsigned ST_BUSY_BIT     = 0;
  localparam int unsigned ST_NMI_BIT      = 1;
  localparam int unsigned ST_RESET_BIT    = 2;
  localparam int unsigned IRQ_W           = 3;
  localparam int unsigned IRQ_DONE_BIT    = 0;
  localparam int unsigned IRQ_NMI_BIT     = 1;
  localparam int unsigned IRQ_RESET_BIT   = 2;
  localparam int unsigned HTRANS_ACT_BIT  = 1;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

endpackage

// [wdt_io_if.sv]
// I/O read bus between the host controller and the watchdog.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface wdt_io_if;
  logic [wdt_pkg::IO_ADDR_W-1:0] io_addr;
  logic                          io_rd;
  logic [wdt_pkg::IO_DATA_W-1:0] io_rdata;
  logic                          io_ack;
  logic                          wdt_nmi;
  logic                          wdt_sys_reset;

  modport device (
    input  io_addr,
    input  io_rd,
    output io_rdata,
    output io_ack,
    output wdt_nmi,
    output wdt_sys_reset
  );

  modport host (
    output io_addr,
    output io_rd,
    input  io_rdata,
    input  io_ack,
    input  wdt_nmi,
    input  wdt_sys_reset
  );
endinterface
`default_nettype wire

// [wdt_sync2.sv]
// Two-stage synchroniser, one chain per bit.
// Assumes asynchronous level inputs such as jumpers.
`timescale 1ns/1ps
`default_nettype none
module wdt_sync2
#(
  parameter int unsigned W = 1
)
(
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
      end
      else if (clk_en)
      begin
        s1_ff[i] <= d[i];
        s2_ff[i] <= s1_ff[i];
      end
    end
  end

  assign q = s2_ff;

endmodule
`default_nettype wire

// [watchdog_unit.sv]
// Watchdog countdown driven by host I/O reads of two ports.
// Assumes the host I/O bus shares hclk; jumpers are asynchronous pins.
//
// Contract
// RQ1: Read of enable port starts countdown
// RQ2: Further enable reads refresh running countdown
// RQ3: Read of disable port stops countdown
// RQ4: Expiry resets CPU or raises NMI
// RQ5: Software refreshes within the selected period
// RQ6: Software refreshes within seventy percent period
// RQ7: Software disables before application exits
// RQ8: Period jumper selects six periods
// RQ9: Action jumper: reset, NMI, or off
// RQ10: Each enable read reloads full period
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module watchdog_unit
  import wdt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned HOLD_CYCLES_P = OUT_HOLD_CYCLES
)
(
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 clk_en,
  // Host I/O bus
  wdt_io_if.device                  io,
  // Jumpers
  input  wire logic [PER_JMP_W-1:0] timeout_period_jumper,
  input  wire logic [ACT_JMP_W-1:0] expiry_action_jumper,
  // Status
  output var  logic                 wdt_running
);

  // ----------------------------------------------------------------
  // Local widths
  // ----------------------------------------------------------------
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES_P + 1);
  localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES_P + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES_P - 1);

  typedef enum logic [1:0] {st_idle, st_run, st_fire} wdt_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wdt_state_t            state_ff;
  wdt_state_t            nxt_state;
  logic [PERIOD_W-1:0]   sec_ff;
  logic [PERIOD_W-1:0]   nxt_sec;
  logic [TICK_W-1:0]     tick_cnt_ff;
  logic [TICK_W-1:0]     nxt_tick_cnt;
  logic [HOLD_W-1:0]     hold_ff;
  logic [HOLD_W-1:0]     nxt_hold;
  logic                  nmi_ff;
  logic                  nxt_nmi;
  logic                  sys_reset_ff;
  logic                  nxt_sys_reset;
  logic                  ack_ff;
  logic [IO_DATA_W-1:0]  rdata_ff;
  logic                  running_ff;
  logic [PER_JMP_W-1:0]  per_q;
  logic [ACT_JMP_W-1:0]  act_q;
  logic [PERIOD_W-1:0]   period_sec;
  wire                   hit_enable;
  wire                   hit_disable;
  wire                   act_reset;
  wire                   act_nmi;
  wire                   act_off;
  wire                   reload;
  wire                   stop;
  wire                   tick;
  wire                   expire;

  // ----------------------------------------------------------------
  // Jumper synchronisers
  // ----------------------------------------------------------------
  wdt_sync2 #(
    .W (PER_JMP_W)
  ) u_per_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (timeout_period_jumper),
    .q       (per_q)
  );

  wdt_sync2 #(
    .W (ACT_JMP_W)
  ) u_act_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (expiry_action_jumper),
    .q       (act_q)
  );

  // ----------------------------------------------------------------
  // Period decode, longest period for unlisted settings
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (per_q)
      PER_SEL_1S:   period_sec = PERIOD_1S; // RQ8
      PER_SEL_2S:   period_sec = PERIOD_2S;
      PER_SEL_10S:  period_sec = PERIOD_10S;
      PER_SEL_20S:  period_sec = PERIOD_20S;
      PER_SEL_110S: period_sec = PERIOD_110S;
      PER_SEL_220S: period_sec = PERIOD_220S;
      default:      period_sec = PERIOD_220S;
    endcase
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign hit_enable  = io.io_rd && (io.io_addr == ENABLE_PORT_ADDR);
  assign hit_disable = io.io_rd && (io.io_addr == DISABLE_PORT_ADDR);
  assign act_reset   = (act_q == ACT_RESET); // RQ9
  assign act_nmi     = (act_q == ACT_NMI); // RQ9
  assign act_off     = !(act_reset || act_nmi); // RQ9
  assign reload      = hit_enable && !act_off && (state_ff != st_fire); // RQ1 RQ2 RQ10
  assign stop        = (state_ff == st_run) && (hit_disable || act_off); // RQ3
  assign tick        = (state_ff == st_run) && (tick_cnt_ff == TICK_LAST);
  assign expire      = tick && (sec_ff == SEC_LAST);

  // ----------------------------------------------------------------
  // Countdown state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_sec      = sec_ff;
    nxt_tick_cnt = tick_cnt_ff;
    nxt_hold     = hold_ff;
    unique case (state_ff)
      st_idle:
      begin
        if (reload)
        begin
          nxt_state    = st_run; // RQ1
          nxt_sec      = period_sec;
          nxt_tick_cnt = '0;
        end
      end
      st_run:
      begin
        if (stop)
        begin
          nxt_state = st_idle; // RQ3
        end
        else if (reload)
        begin
          nxt_sec      = period_sec; // RQ10
          nxt_tick_cnt = '0; // RQ2
        end
        else if (expire)
        begin
          nxt_state = st_fire; // RQ4
          nxt_hold  = HOLD_LAST;
        end
        else if (tick)
        begin
          nxt_sec      = sec_ff - 1'b1;
          nxt_tick_cnt = '0;
        end
        else
        begin
          nxt_tick_cnt = tick_cnt_ff + 1'b1;
        end
      end
      st_fire:
      begin
        if (hold_ff == '0)
        begin
          nxt_state = st_idle;
        end
        else
        begin
          nxt_hold = hold_ff - 1'b1;
        end
      end
    endcase
  end

  // Expiry action latched on entry to the fire state
  assign nxt_nmi       = (nxt_state == st_fire) && ((state_ff == st_fire) ? nmi_ff : act_nmi); // RQ4
  assign nxt_sys_reset = (nxt_state == st_fire) && ((state_ff == st_fire) ? sys_reset_ff : act_reset); // RQ4

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff    <= st_idle;
      sec_ff      <= '0;
      tick_cnt_ff <= '0;
      hold_ff     <= '0;
    end
    else if (clk_en)
    begin
      state_ff    <= nxt_state;
      sec_ff      <= nxt_sec;
      tick_cnt_ff <= nxt_tick_cnt;
      hold_ff     <= nxt_hold;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nmi_ff       <= 1'b0;
      sys_reset_ff <= 1'b0;
      running_ff   <= 1'b0;
    end
    else if (clk_en)
    begin
      nmi_ff       <= nxt_nmi;
      sys_reset_ff <= nxt_sys_reset;
      running_ff   <= (nxt_state == st_run);
    end
  end

  // ----------------------------------------------------------------
  // I/O read answer, value has no meaning
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= IO_READ_VALUE;
    end
    else if (clk_en)
    begin
      ack_ff   <= hit_enable || hit_disable;
      rdata_ff <= IO_READ_VALUE; // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io.io_ack        = ack_ff;
  assign io.io_rdata      = rdata_ff;
  assign io.wdt_nmi       = nmi_ff;
  assign io.wdt_sys_reset = sys_reset_ff;
  assign wdt_running      = running_ff;

endmodule
`default_nettype wire

// [wdt_host_ctrl.sv]
// Host-side controller: AHB-Lite registers issuing watchdog I/O reads.
// Assumes one AHB-Lite master, word transfers, and the watchdog on hclk.
`timescale 1ns/1ps
`default_nettype none
module wdt_host_ctrl
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  // Interrupt
  output var  logic        irq,
  // Watchdog I/O bus
  wdt_io_if.host           io
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 wr_ff;
  logic [REG_DEC_W-1:0] waddr_ff;
  logic [31:0]          hrdata_ff;
  logic                 busy_ff;
  logic                 io_rd_ff;
  logic [IO_ADDR_W-1:0] io_addr_ff;
  logic [IO_DATA_W-1:0] rd_data_ff;
  logic [IRQ_W-1:0]     irq_stat_ff;
  logic [IRQ_W-1:0]     irq_mask_ff;
  logic                 nmi_q_ff;
  logic                 rst_q_ff;
  logic [31:0]          rd_mux;
  wire                  take;
  wire                  cmd_wr;
  wire                  cmd_go;
  wire                  cmd_dis;
  wire                  stat_wr;
  wire                  mask_wr;
  wire [IRQ_W-1:0]      irq_set;
  wire [IRQ_W-1:0]      irq_clr;
  wire [IRQ_W-1:0]      nxt_irq_stat;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign take    = hsel && hready && htrans[HTRANS_ACT_BIT];
  assign cmd_wr  = wr_ff && (waddr_ff == REG_CMD) && !busy_ff;
  assign cmd_dis = hwdata[CMD_DISABLE_BIT];
  assign cmd_go  = cmd_wr && (hwdata[CMD_ENABLE_BIT] || cmd_dis);
  assign stat_wr = wr_ff && (waddr_ff == REG_IRQ_STATUS);
  assign mask_wr = wr_ff && (waddr_ff == REG_IRQ_MASK);

  always_comb
  begin
    rd_mux = WORD_ZERO;
    unique case (haddr[REG_DEC_W-1:0])
      REG_STATUS:
      begin
        rd_mux[ST_BUSY_BIT]  = busy_ff;
        rd_mux[ST_NMI_BIT]   = io.wdt_nmi;
        rd_mux[ST_RESET_BIT] = io.wdt_sys_reset;
      end
      REG_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      REG_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_ff;
      REG_READ_DATA:  rd_mux[IO_DATA_W-1:0] = rd_data_ff;
      default:        rd_mux = WORD_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Sticky events, set wins over clear
  // ----------------------------------------------------------------
  assign irq_set[IRQ_DONE_BIT]  = busy_ff && io.io_ack;
  assign irq_set[IRQ_NMI_BIT]   = io.wdt_nmi && !nmi_q_ff;
  assign irq_set[IRQ_RESET_BIT] = io.wdt_sys_reset && !rst_q_ff;
  assign irq_clr      = stat_wr ? hwdata[IRQ_W-1:0] : '0;
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ff     <= 1'b0;
      waddr_ff  <= '0;
      hrdata_ff <= WORD_ZERO;
    end
    else if (clk_en)
    begin
      wr_ff     <= take && hwrite;
      waddr_ff  <= haddr[REG_DEC_W-1:0];
      hrdata_ff <= (take && !hwrite) ? rd_mux : hrdata_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_ff     <= 1'b0;
      io_rd_ff    <= 1'b0;
      io_addr_ff  <= '0;
      rd_data_ff  <= '0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      nmi_q_ff    <= 1'b0;
      rst_q_ff    <= 1'b0;
    end
    else if (clk_en)
    begin
      busy_ff     <= cmd_go || (busy_ff && !io.io_ack);
      io_rd_ff    <= cmd_go; // RQ5 RQ7
      io_addr_ff  <= cmd_go ? (cmd_dis ? DISABLE_PORT_ADDR : ENABLE_PORT_ADDR) : io_addr_ff;
      rd_data_ff  <= irq_set[IRQ_DONE_BIT] ? io.io_rdata : rd_data_ff;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= mask_wr ? hwdata[IRQ_W-1:0] : irq_mask_ff;
      nmi_q_ff    <= io.wdt_nmi;
      rst_q_ff    <= io.wdt_sys_reset;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout  = clk_en;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_ff;
  assign irq        = |(irq_stat_ff & irq_mask_ff);
  assign io.io_rd   = io_rd_ff;
  assign io.io_addr = io_addr_ff;

endmodule
`default_nettype wire

// [wdt_io_properties.sv]
// Concurrent checks on the watchdog I/O link between host controller and watchdog.
// Assumes one clock and the link signals handed in as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module wdt_io_properties
  import wdt_pkg::*;
#(
  parameter int unsigned TICK_P = 20,
  parameter int unsigned HOLD_P = 4
)
(
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // Link
  input  wire logic [IO_ADDR_W-1:0] io_addr,
  input  wire logic                 io_rd,
  input  wire logic [IO_DATA_W-1:0] io_rdata,
  input  wire logic                 io_ack,
  input  wire logic                 wdt_nmi,
  input  wire logic                 wdt_sys_reset
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int LONGEST = 220 * TICK_P;
  wire en_rd  = io_rd && (io_addr == ENABLE_PORT_ADDR);
  wire dis_rd = io_rd && (io_addr == DISABLE_PORT_ADDR);
  wire fire   = wdt_nmi || wdt_sys_reset;
  logic [15:0] since_en_ff;
  logic        armed_ff;
  logic [7:0]  out_cnt_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      since_en_ff <= 16'h0000;
      armed_ff    <= 1'b0;
      out_cnt_ff  <= 8'h00;
    end
    else
    begin
      since_en_ff <= en_rd ? 16'h0000 : (since_en_ff == 16'hFFFF ? since_en_ff : since_en_ff + 16'h0001);
      armed_ff    <= en_rd ? 1'b1 : ((dis_rd || fire) ? 1'b0 : armed_ff);
      out_cnt_ff  <= fire ? out_cnt_ff + 8'h01 : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_enable_read_acked: assert property (en_rd |=> io_ack && io_rdata == IO_READ_VALUE)
    else $error("enable read not acknowledged next cycle");
  a_disable_read_acked: assert property (dis_rd |=> io_ack)
    else $error("disable read not acknowledged next cycle");
  a_ack_after_read: assert property (io_ack |-> $past(io_rd))
    else $error("acknowledge without a read");
  a_expiry_not_early: assert property ($rose(fire) |-> since_en_ff >= TICK_P)
    else $error("expiry before a full period");
  a_expiry_not_late: assert property ($rose(fire) |-> since_en_ff <= LONGEST)
    else $error("expiry after the longest period");
  a_expiry_needs_arm: assert property ($rose(fire) |-> armed_ff)
    else $error("expiry while disabled");
  a_single_action: assert property (!(wdt_nmi && wdt_sys_reset))
    else $error("both expiry actions at once");
  a_output_width: assert property ($fell(fire) |-> out_cnt_ff == HOLD_P)
    else $error("expiry output width wrong");

  c_nmi_fired: cover property ($rose(wdt_nmi));
  c_reset_fired: cover property ($rose(wdt_sys_reset));
  c_disable_read: cover property (dis_rd);
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench: host controller and watchdog joined by the I/O link, driven over AHB-Lite.
// Assumes zero-wait-state slave and a shortened tick of 20 cycles per second.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wdt_pkg::*;
;
  localparam int TICK = 20;
  localparam int HOLD = 4;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hreadyout;
  wire  logic [31:0] hrdata;
  wire  logic  hresp;
  wire  logic  irq;
  wire  logic  running;
  logic [3:0]  timeout_period_jumper;
  logic [1:0]  expiry_action_jumper;
  int          bad_count;
  int          cmp_count;
  int          cyc_count;
  logic [31:0] r;

  wdt_io_if link_if();

  wdt_host_ctrl wdt_host_ctrl_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .io(link_if));

  watchdog_unit #(.TICK_CYCLES_P(TICK), .HOLD_CYCLES_P(HOLD)) watchdog_unit_i (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .io(link_if), .timeout_period_jumper(timeout_period_jumper),
    .expiry_action_jumper(expiry_action_jumper), .wdt_running(running));

  wdt_io_properties #(.TICK_P(TICK), .HOLD_P(HOLD)) wdt_io_properties_i (.hclk(hclk), .hresetn(hresetn),
    .io_addr(link_if.io_addr), .io_rd(link_if.io_rd), .io_rdata(link_if.io_rdata), .io_ack(link_if.io_ack),
    .wdt_nmi(link_if.wdt_nmi), .wdt_sys_reset(link_if.wdt_sys_reset));

  // ----------------------------------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    #1;
  endtask

  task automatic cmd(input logic [31:0] bits);
    int n;
    ahb(1'b1, REG_CMD, bits, r);
    n = 0;
    r = 32'h0000_0001;
    while (r[ST_BUSY_BIT] !== 1'b0 && n < 20)
    begin
      ahb(1'b0, REG_STATUS, WORD_ZERO, r);
      n++;
    end
    chk({31'h0, r[ST_BUSY_BIT]}, WORD_ZERO);
  endtask

  task automatic run_expiry(input logic [3:0] code, input int secs, input logic [1:0] act);
    int n;
    int ev;
    timeout_period_jumper <= code;
    expiry_action_jumper  <= act;
    cyc(4);
    cmd(32'h0000_0001);
    chk({31'h0, running}, 32'h0000_0001);
    cyc(secs * TICK - 8);
    chk({30'h0, link_if.wdt_nmi, link_if.wdt_sys_reset}, 32'h0000_0000);
    n = 0;
    while (!(link_if.wdt_nmi || link_if.wdt_sys_reset) && n < 16)
    begin
      cyc(1);
      n++;
    end
    chk({30'h0, link_if.wdt_nmi, link_if.wdt_sys_reset}, (act == ACT_NMI) ? 32'h0000_0002 : 32'h0000_0001);
    ev = (act == ACT_NMI) ? IRQ_NMI_BIT : IRQ_RESET_BIT;
    ahb(1'b0, REG_IRQ_STATUS, WORD_ZERO, r);
    chk(r, (32'h1 << IRQ_DONE_BIT) | (32'h1 << ev));
    chk({31'h0, irq}, 32'h0000_0000);
    ahb(1'b1, REG_IRQ_MASK, 32'h0000_0007, r);
    chk({31'h0, irq}, 32'h0000_0001);
    ahb(1'b1, REG_IRQ_STATUS, 32'h0000_0007, r);
    chk({31'h0, irq}, 32'h0000_0000);
    ahb(1'b1, REG_IRQ_MASK, WORD_ZERO, r);
    cyc(HOLD + 2);
    chk({31'h0, running}, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [7:0] offs [6] = '{REG_CMD, REG_STATUS, REG_IRQ_STATUS, REG_IRQ_MASK, REG_READ_DATA, 8'h20};
  logic [3:0] codes [6] = '{PER_SEL_1S, PER_SEL_2S, PER_SEL_10S, PER_SEL_20S, PER_SEL_110S, PER_SEL_220S};
  int         secs [6] = '{1, 2, 10, 20, 110, 220};

  initial
  begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = WORD_ZERO;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = WORD_ZERO;
    timeout_period_jumper = PER_SEL_1S;
    expiry_action_jumper = ACT_RESET;
    bad_count = 0;
    cmp_count = 0;
    cyc_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    foreach (offs[i])
    begin
      ahb(1'b0, offs[i], WORD_ZERO, r);
      chk(r, WORD_ZERO);
    end
    ahb(1'b1, REG_IRQ_MASK, 32'h0000_0005, r);
    ahb(1'b0, REG_IRQ_MASK, WORD_ZERO, r);
    chk(r, 32'h0000_0005);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF, r);
    ahb(1'b0, 8'h20, WORD_ZERO, r);
    chk(r, WORD_ZERO);
    chk({31'h0, hresp}, WORD_ZERO);
    ahb(1'b1, REG_IRQ_MASK, WORD_ZERO, r);
    $display("Test registers done");
    cmd(32'h0000_0001);
    cyc(5);
    for (int k = 0; k < 3; k++)
    begin
      cmd(32'h0000_0001);
      cyc(5);
      chk({30'h0, running, link_if.wdt_sys_reset}, 32'h0000_0002);
    end
    clk_en <= 1'b0;
    cyc(20);
    clk_en <= 1'b1;
    chk({30'h0, running, link_if.wdt_sys_reset}, 32'h0000_0002);
    ahb(1'b0, REG_READ_DATA, WORD_ZERO, r);
    chk(r, {24'h00_0000, IO_READ_VALUE});
    cmd(32'h0000_0003);
    chk({31'h0, running}, 32'h0000_0000);
    cyc(3 * TICK);
    chk({30'h0, link_if.wdt_nmi, link_if.wdt_sys_reset}, 32'h0000_0000);
    $display("Test refresh and disable done");
    foreach (codes[i])
      run_expiry(codes[i], secs[i], i[0] ? ACT_NMI : ACT_RESET);
    $display("Test periods and actions done");
    for (int k = 0; k < 2; k++)
    begin
      expiry_action_jumper <= k[0] ? 2'b11 : 2'b00;
      timeout_period_jumper <= PER_SEL_1S;
      cyc(4);
      cmd(32'h0000_0001);
      chk({31'h0, running}, 32'h0000_0000);
      cyc(2 * TICK);
      chk({30'h0, link_if.wdt_nmi, link_if.wdt_sys_reset}, 32'h0000_0000);
    end
    $display("Test action off done");
    conclude();
  end
endmodule
`default_nettype wire
